// ===== rtl/urxerr_params.svh
// Purpose: constants of the receive error block
// Assumes: byte addresses on the register bus
// Notes: one definition per figure
`ifndef URXERR_PARAMS_SVH
`define URXERR_PARAMS_SVH

// register byte offsets
`define URXERR_OFF_DATA 8'h00
`define URXERR_OFF_STAT 8'h04
`define URXERR_OFF_FLAGS 8'h18
`define URXERR_OFF_LCTL 8'h2C
`define URXERR_OFF_ISTAT 8'h40
`define URXERR_OFF_IMASK 8'h44

// line_control fields
`define URXERR_LCTL_PEN 1
`define URXERR_LCTL_EPS 2
`define URXERR_LCTL_FEN 4
`define URXERR_LCTL_SPS 7
`define URXERR_LCTL_RST 8'h00

// line_flags fields and reset image
`define URXERR_FLG_BUSY 3
`define URXERR_FLG_RX_EMPTY 4
`define URXERR_FLG_TX_FULL 5
`define URXERR_FLG_RX_FULL 6
`define URXERR_FLG_TX_EMPTY 7
`define URXERR_FLAGS_RST 32'h0000_0090

// error bits inside the data word
`define URXERR_DR_ERR_LSB 8

// event bits of the interrupt status
`define URXERR_EV_W 5

// timing
`define URXERR_CLK_HZ 10000000
`define URXERR_BAUD 115200
`define URXERR_CLKS_PER_BIT (`URXERR_CLK_HZ / `URXERR_BAUD)
`define URXERR_FIFO_DEPTH 16

`endif

// ===== rtl/urxerr_pkg.sv
// Purpose: shared types of the receive error block
// Assumes: eight data bits per character
// Notes: status bit order is oe, brk, par, frm
`include "urxerr_params.svh"
package urxerr_pkg;

    typedef struct packed {
        logic oe;
        logic brk;
        logic par;
        logic frm;
    } urxerr_err_s;

    typedef struct packed {
        logic brk;
        logic par;
        logic frm;
        logic [7:0] data;
    } urxerr_char_s;

    typedef struct packed {
        logic sps;
        logic eps;
        logic pen;
    } urxerr_pcfg_s;

    typedef enum logic [2:0] {
        URXERR_IDLE,
        URXERR_START,
        URXERR_DATA,
        URXERR_PAR,
        URXERR_STOP,
        URXERR_BRKW
    } urxerr_fst_e;

    typedef struct packed {
        urxerr_fst_e st;
        logic [15:0] cnt;
        logic [2:0] bitn;
        logic [7:0] shift;
        logic all_low;
        logic perr;
        logic done;
        urxerr_char_s chr;
    } urxerr_frame_s;

    typedef struct packed {
        logic ack;
        logic rdvalid;
        logic [31:0] rdata;
        urxerr_err_s err;
        logic [7:0] lctl;
        logic [`URXERR_EV_W-1:0] ist;
        logic [`URXERR_EV_W-1:0] imask;
    } urxerr_top_s;

endpackage

// ===== rtl/urxerr_fifo.sv
// Purpose: receive character store in flip-flops
// Assumes: caller never pushes while full
// Notes: with fen low it behaves as a one-entry holding register
module urxerr_fifo #(
    parameter int W = 11,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // control
    input wire logic i_fen,
    input wire logic i_push,
    input wire logic [W-1:0] i_wdata,
    input wire logic i_pop,
    // state
    output logic [W-1:0] o_head,
    output logic o_full,
    output logic o_empty,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    import urxerr_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } urxerr_fifo_s;

    urxerr_fifo_s st, next_st;
    logic do_push, do_pop;

    assign o_empty = (st.cnt == '0);
    assign o_full = i_fen ? (st.cnt == CW'(DEPTH)) : !o_empty;
    assign o_head = st.mem[st.rp];
    assign o_count = st.cnt;
    assign do_push = i_push && !o_full;
    assign do_pop = i_pop && !o_empty;

    always_comb begin
        next_st = st;
        if (do_push) begin
            next_st.mem[st.wp] = i_wdata;
            next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (do_pop) begin
            next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + CW'(do_push) - CW'(do_pop);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ===== rtl/urxerr_frame.sv
// Purpose: serial character receiver with break detection
// Assumes: i_rxd already synchronous to i_clk_sys
// Notes: samples each bit at its middle, lsb first
module urxerr_frame #(
    parameter int CLKS_PER_BIT = 86
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // line and configuration
    input wire logic i_rxd,
    input wire urxerr_pkg::urxerr_pcfg_s i_pcfg,
    // character out
    output logic o_done,
    output urxerr_pkg::urxerr_char_s o_char,
    output logic o_busy
);
    import urxerr_pkg::*;
    localparam logic [15:0] FULL = 16'(CLKS_PER_BIT - 1);
    localparam logic [15:0] HALF = 16'(CLKS_PER_BIT / 2);

    urxerr_frame_s st, next_st;
    logic tick;

    assign tick = (st.cnt == '0);
    assign o_done = st.done;
    assign o_char = st.chr;
    assign o_busy = (st.st != URXERR_IDLE);

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.cnt = tick ? FULL : st.cnt - 1'b1;
        unique case (st.st)
            URXERR_IDLE: begin
                next_st.cnt = HALF;
                if (!i_rxd) begin
                    next_st.st = URXERR_START;
                end
            end
            URXERR_START: if (tick) begin
                // glitch shorter than half a bit is not a start
                next_st.st = i_rxd ? URXERR_IDLE : URXERR_DATA;
                next_st.bitn = '0;
                next_st.all_low = 1'b1;
                next_st.perr = 1'b0;
            end
            URXERR_DATA: if (tick) begin
                next_st.shift = {i_rxd, st.shift[7:1]};
                next_st.all_low = st.all_low && !i_rxd;
                next_st.bitn = st.bitn + 1'b1;
                if (st.bitn == 3'h7) begin
                    next_st.st = i_pcfg.pen ? URXERR_PAR : URXERR_STOP;
                end
            end
            URXERR_PAR: if (tick) begin
                next_st.all_low = st.all_low && !i_rxd;
                if (i_pcfg.sps) begin
                    next_st.perr = (i_rxd == i_pcfg.eps);
                end else begin
                    next_st.perr = i_pcfg.eps ? ^{st.shift, i_rxd} : ~^{st.shift, i_rxd};
                end
                next_st.st = URXERR_STOP;
            end
            URXERR_STOP: if (tick) begin
                next_st.done = 1'b1;
                next_st.chr.frm = !i_rxd;
                next_st.chr.brk = st.all_low && !i_rxd;
                next_st.chr.par = st.perr;
                // one zero character per break, however long it lasts
                next_st.chr.data = (st.all_low && !i_rxd) ? 8'h00 : st.shift;
                next_st.st = (st.all_low && !i_rxd) ? URXERR_BRKW : URXERR_IDLE;
            end
            URXERR_BRKW: if (i_rxd) begin
                next_st.st = URXERR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    a_brk_no_more: assert property (
        st.st == URXERR_BRKW && !i_rxd |=> !st.done && st.st == URXERR_BRKW)
        else $error("character produced while break still held");
    a_stop_sample: assert property (
        st.st == URXERR_STOP && tick |=> st.done && st.chr.frm == !$past(i_rxd))
        else $error("framing result does not follow stop bit");
endmodule

// ===== rtl/urxerr_top.sv
// Purpose: serial receive path with error status, clear and flags
// Assumes: avalon-mm slave, one wait state per access, 10 MHz clock
// Notes: no transmit path; transmit flags read as idle
//
// Implementation choice: the Avalon-MM slave port.
`include "urxerr_params.svh"
module urxerr_top #(
    parameter int CLKS_PER_BIT = `URXERR_CLKS_PER_BIT,
    parameter int FIFO_DEPTH = `URXERR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // serial line
    input wire logic i_rxd,
    // interrupt
    output logic o_irq
);
    import urxerr_pkg::*;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    urxerr_top_s st, next_st;
    urxerr_char_s rx_char;
    urxerr_char_s head;
    urxerr_pcfg_s pcfg;
    logic rx_done;
    logic rx_busy;
    logic fifo_full;
    logic fifo_empty;
    logic [CW-1:0] fifo_cnt;
    logic push;
    logic pop;
    logic ovr_evt;
    logic req;
    logic take_rd;
    logic take_wr;
    logic stat_clr;
    logic [31:0] flags_w;
    logic [31:0] rd_word;
    logic [`URXERR_EV_W-1:0] ev;

    ////////////////////////////////////////////////////////////////////////
    // receiver and store

    assign pcfg.pen = st.lctl[`URXERR_LCTL_PEN];
    assign pcfg.eps = st.lctl[`URXERR_LCTL_EPS];
    assign pcfg.sps = st.lctl[`URXERR_LCTL_SPS];

    urxerr_frame #(
        .CLKS_PER_BIT(CLKS_PER_BIT)
    ) u_frame (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_rxd(i_rxd),
        .i_pcfg(pcfg),
        .o_done(rx_done),
        .o_char(rx_char),
        .o_busy(rx_busy)
    );

    // overrun drops the character; stored entries stay valid
    assign ovr_evt = rx_done && fifo_full;
    assign push = rx_done && !fifo_full;

    urxerr_fifo #(
        .W($bits(urxerr_char_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_fen(st.lctl[`URXERR_LCTL_FEN]),
        .i_push(push),
        .i_wdata(rx_char),
        .i_pop(pop),
        .o_head(head),
        .o_full(fifo_full),
        .o_empty(fifo_empty),
        .o_count(fifo_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode: first cycle waits, second cycle completes

    assign req = i_avs_read || i_avs_write;
    assign take_rd = i_avs_read && st.ack;
    assign take_wr = i_avs_write && st.ack;
    // status location clears on any write, value ignored; reads return the error status
    assign stat_clr = take_wr && hit(i_avs_address, `URXERR_OFF_STAT);
    // pop only a character whose data was captured for this read
    assign pop = take_rd && hit(i_avs_address, `URXERR_OFF_DATA) && st.rdvalid;

    assign flags_w = `URXERR_FLAGS_RST
        & ~(32'h1 << `URXERR_FLG_RX_EMPTY)
        | (32'(fifo_empty) << `URXERR_FLG_RX_EMPTY)
        | (32'(fifo_full) << `URXERR_FLG_RX_FULL)
        | (32'(rx_busy) << `URXERR_FLG_BUSY);

    assign ev = {ovr_evt, rx_done && rx_char.brk, rx_done && rx_char.par,
        rx_done && rx_char.frm, push};

    always_comb begin
        rd_word = 32'h0000_0000;
        case (i_avs_address)
            `URXERR_OFF_DATA: begin
                if (!fifo_empty) begin
                    rd_word = {20'h0_0000, st.err.oe, head.brk, head.par, head.frm, head.data};
                end
            end
            `URXERR_OFF_STAT: rd_word = {28'h000_0000, st.err};
            `URXERR_OFF_FLAGS: rd_word = flags_w;
            `URXERR_OFF_LCTL: rd_word = {24'h00_0000, st.lctl};
            `URXERR_OFF_ISTAT: rd_word = {27'h000_0000, st.ist};
            `URXERR_OFF_IMASK: rd_word = {27'h000_0000, st.imask};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // register state

    always_comb begin
        next_st = st;
        next_st.ack = req && !st.ack;
        if (req && !st.ack) begin
            next_st.rdata = i_avs_read ? rd_word : 32'h0000_0000;
            next_st.rdvalid = i_avs_read && hit(i_avs_address, `URXERR_OFF_DATA)
                && !fifo_empty;
        end
        if (pop) begin
            // status now tracks the character just handed out
            next_st.err.brk = head.brk;
            next_st.err.par = head.par;
            next_st.err.frm = head.frm;
        end
        if (stat_clr) begin
            next_st.err = '0;
        end
        if (take_wr && hit(i_avs_address, `URXERR_OFF_LCTL) && i_avs_byteenable[0]) begin
            next_st.lctl = i_avs_writedata[7:0];
        end
        if (take_wr && hit(i_avs_address, `URXERR_OFF_ISTAT) && i_avs_byteenable[0]) begin
            next_st.ist = st.ist & ~i_avs_writedata[`URXERR_EV_W-1:0];
        end
        if (take_wr && hit(i_avs_address, `URXERR_OFF_IMASK) && i_avs_byteenable[0]) begin
            next_st.imask = i_avs_writedata[`URXERR_EV_W-1:0];
        end
        // hardware sets are applied last so they win over clears
        if (ovr_evt) begin
            next_st.err.oe = 1'b1;
        end
        next_st.ist = next_st.ist | ev;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_avs_readdata = st.rdata;
    assign o_avs_waitrequest = req && !st.ack;
    assign o_irq = |(st.ist & st.imask);

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    a_ovr_sets_flag: assert property (
        ovr_evt |=> st.err.oe && st.ist[4])
        else $error("overrun did not raise flag next cycle");

    a_ovr_keeps_fifo: assert property (
        ovr_evt && !pop |=> fifo_cnt == $past(fifo_cnt) && head == $past(head))
        else $error("overrun altered stored characters");

    a_clear_all: assert property (
        stat_clr && !ovr_evt |=> st.err == 4'h0)
        else $error("clear write left an error flag set");

    a_stat_readonly: assert property (
        stat_clr |=> $stable(st.lctl) && $stable(st.imask)
            && !(st.err.frm || st.err.par || st.err.brk))
        else $error("write to status location stored data");

    a_brk_zero_char: assert property (
        push && rx_char.brk |-> rx_char.data == 8'h00)
        else $error("break stored a non-zero character");

    a_status_follows: assert property (
        pop && !stat_clr |=> st.err.par == $past(head.par)
            && st.err.brk == $past(head.brk) && st.err.frm == $past(head.frm))
        else $error("status does not describe last read character");

    a_set_beats_clr: assert property (
        stat_clr && ovr_evt |=> st.err.oe)
        else $error("overrun lost against simultaneous clear");

    a_flags_reset: assert property (
        $rose(i_rst_b) |-> flags_w[`URXERR_FLG_RX_EMPTY] && flags_w[`URXERR_FLG_TX_EMPTY]
            && !flags_w[`URXERR_FLG_RX_FULL] && !flags_w[`URXERR_FLG_TX_FULL])
        else $error("flag register reset image wrong");

    a_bus_answer: assert property (
        req && !st.ack |=> !o_avs_waitrequest || !req)
        else $error("access not answered after one wait cycle");

    c_overrun: cover property (ovr_evt ##[1:200] stat_clr);
    c_break: cover property (push && rx_char.brk);
    c_parity_read: cover property (pop && head.par);
    c_irq: cover property ($rose(o_irq));
endmodule

// ===== testbench/urxerr_line_drv.sv
// Purpose: far-end serial transmitter feeding the receive line
// Assumes: called just after a rising edge of i_clk_sys
// Notes: line idles high; parity and stop bit values come from the caller
module urxerr_line_drv #(
    parameter int CPB = 8
) (
    // clock
    input wire logic i_clk_sys,
    // serial line
    output logic o_rxd
);
    timeunit 1ns;
    timeprecision 1ns;

    initial o_rxd = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    task automatic hold(input logic v, input int nbits);
        o_rxd <= v;
        repeat (nbits * CPB) @(posedge i_clk_sys);
    endtask

    // wrong parity or a low stop bit only when the caller asks for it
    task automatic send(input logic [7:0] d, input logic pen, input logic par, input logic stop);
        hold(1'b0, 1);
        for (int i = 0; i < 8; i++) begin
            hold(d[i], 1);
        end
        if (pen) begin
            hold(par, 1);
        end
        hold(stop, 1);
        hold(1'b1, 2); // marking level between frames
    endtask
endmodule

// ===== testbench/urxerr_top_tb.sv
// Purpose: self-checking bench for the receive error block
// Assumes: one wait state per access, short bit time and fifo depth
// Notes: waitrequest and read data are sampled at the rising edge
module urxerr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CPB = 8;
    localparam int FD = 4;

    logic clk = 1'b0;
    logic rst_b;
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] ben;
    logic [31:0] rdata;
    logic wq;
    logic rxd;
    logic irq;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] modes [4] = '{8'h12, 8'h16, 8'h92, 8'h96};
    logic [7:0] d;
    logic p;

    always #50 clk = ~clk;

    urxerr_top #(.CLKS_PER_BIT(CPB), .FIFO_DEPTH(FD)) urxerr_top_i (
        .i_clk_sys(clk),
        .i_rst_b(rst_b),
        .i_avs_address(addr),
        .i_avs_read(rd),
        .i_avs_write(wr),
        .i_avs_writedata(wdata),
        .i_avs_byteenable(ben),
        .o_avs_readdata(rdata),
        .o_avs_waitrequest(wq),
        .i_rxd(rxd),
        .o_irq(irq)
    );

    urxerr_line_drv #(.CPB(CPB)) urxerr_line_drv_i (
        .i_clk_sys(clk),
        .o_rxd(rxd)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // extra edge at the end keeps back-to-back calls from double driving
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dv,
                       output logic [31:0] q);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= dv;
        ben <= 4'hF;
        do begin
            @(posedge clk);
        end while (wq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wrr(input logic [7:0] a, input logic [31:0] dv);
        logic [31:0] q;
        bus(a, 1'b1, dv, q);
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string n);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        check(n, e, q & m);
    endtask

    task automatic chk_irq(input logic e);
        @(negedge clk);
        check("irq", {31'h0, e}, {31'h0, irq});
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            $display("ERROR timeout expected %h seen %h", 32'h0, cyc);
            conclude();
        end
    end

    initial begin
        rst_b = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        ben = 4'hF;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(8'h18, 32'hFF, 32'h90, "flags");
        chk(8'h04, 32'hF, 32'h0, "status");
        wrr(8'h04, 32'h0F);
        chk(8'h04, 32'hF, 32'h0, "status");
        chk(8'h80, 32'hFFFFFFFF, 32'h0, "unmapped");
        // odd, even, stick one, stick zero; good then bad parity
        for (int m = 0; m < 4; m++) begin
            wrr(8'h2C, {24'h0, modes[m]});
            for (int e = 0; e < 2; e++) begin
                d = 8'h5A + 8'(m);
                p = modes[m][7] ? !modes[m][2] : (^d ^ !modes[m][2]);
                urxerr_line_drv_i.send(d, 1'b1, p ^ e[0], 1'b1);
                chk(8'h00, 32'h7FF, {22'h0, e[0], 1'b0, d}, "data");
                chk(8'h04, 32'hF, {30'h0, e[0], 1'b0}, "status");
            end
        end
        wrr(8'h2C, 32'h10);
        urxerr_line_drv_i.send(8'h81, 1'b0, 1'b0, 1'b0);
        chk(8'h00, 32'h7FF, 32'h181, "data");
        chk(8'h04, 32'hF, 32'h1, "status");
        wrr(8'h04, 32'hA5);
        chk(8'h04, 32'hF, 32'h0, "status");
        for (int k = 0; k <= FD; k++) begin
            urxerr_line_drv_i.send(8'h10 + 8'(k), 1'b0, 1'b0, 1'b1);
        end
        chk(8'h04, 32'hF, 32'h8, "status");
        chk(8'h18, 32'h50, 32'h40, "flags");
        for (int k = 0; k < FD; k++) begin
            chk(8'h00, 32'h7FF, 32'h10 + k, "data");
        end
        chk(8'h18, 32'h50, 32'h10, "flags");
        urxerr_line_drv_i.send(8'h77, 1'b0, 1'b0, 1'b1);
        chk(8'h00, 32'hFF, 32'h77, "data");
        wrr(8'h04, 32'h0);
        // long break: only one zero character expected
        urxerr_line_drv_i.hold(1'b0, 30);
        urxerr_line_drv_i.hold(1'b1, 2);
        chk(8'h00, 32'h7FF, 32'h500, "data");
        chk(8'h04, 32'hF, 32'h5, "status");
        chk(8'h18, 32'h10, 32'h10, "flags");
        urxerr_line_drv_i.send(8'h3C, 1'b0, 1'b0, 1'b1);
        chk(8'h00, 32'h7FF, 32'h3C, "data");
        wrr(8'h04, 32'h0);
        chk(8'h04, 32'hF, 32'h0, "status");
        // interrupt on stored character: raise, mask, unmask, clear
        wrr(8'h40, 32'h1F);
        wrr(8'h44, 32'h01);
        chk_irq(1'b0);
        urxerr_line_drv_i.send(8'h66, 1'b0, 1'b0, 1'b1);
        chk_irq(1'b1);
        wrr(8'h44, 32'h00);
        chk_irq(1'b0);
        chk(8'h40, 32'h1F, 32'h01, "istat");
        wrr(8'h44, 32'h01);
        chk_irq(1'b1);
        wrr(8'h40, 32'h01);
        chk_irq(1'b0);
        chk(8'h00, 32'hFF, 32'h66, "data");
        conclude();
    end
endmodule
